// ---- epc_pkg.sv ----
package epc_pkg;
  // ----------------------------------------
  // Opcode fields, widths and reset values
  // ----------------------------------------
  localparam logic [7:0] OPC_ADD_PTR_HI = 8'he8;
  localparam logic [15:0] OPC_CALL_W = 16'h0014;
  localparam logic [1:0] SEL_FRAME_RET = 2'h3;
  localparam logic [1:0] SEL_FRAME_TWO = 2'h2;
  localparam int LIT_W = 6;
  localparam int PTR_W = 12;
  localparam int PC_W = 21;
  localparam logic [PC_W-1:0] RET_STEP = 21'h000002;
  localparam logic [PTR_W-1:0] PTR_RST = 12'h000;
  localparam logic [PC_W-1:0] PC_RST = 21'h000000;

  typedef enum logic [1:0] {
    EPC_IDLE,
    EPC_RET_NOP,
    EPC_CALL_NOP
  } epc_state_t;
endpackage

// ---- epc_dec_if.sv ----
`timescale 1ns/1ps
interface epc_dec_if;
  logic is_add_ptr;
  logic is_add_ret;
  logic is_call_w;
  logic [1:0] sel;
  logic [epc_pkg::LIT_W-1:0] lit;
  modport dec (output is_add_ptr, output is_add_ret, output is_call_w, output sel, output lit);
  modport exe (input is_add_ptr, input is_add_ret, input is_call_w, input sel, input lit);
endinterface

// ---- epc_decoder.sv ----
`timescale 1ns/1ps
module epc_decoder (
  // Instruction in
  input wire logic [15:0] instr_i,
  input wire logic instr_valid_i,
  input wire logic ext_en_i,
  // Decoded fields
  epc_dec_if.dec d
);
  logic add_grp;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  // Only the extension opcodes are recognised; all else is left to the core
  assign add_grp = instr_valid_i && ext_en_i && (instr_i[15:8] == epc_pkg::OPC_ADD_PTR_HI);
  assign d.sel = instr_i[7:6];
  assign d.lit = instr_i[epc_pkg::LIT_W-1:0];
  assign d.is_add_ptr = add_grp && (instr_i[7:6] != epc_pkg::SEL_FRAME_RET);
  assign d.is_add_ret = add_grp && (instr_i[7:6] == epc_pkg::SEL_FRAME_RET);
  assign d.is_call_w = instr_valid_i && ext_en_i && (instr_i == epc_pkg::OPC_CALL_W);
endmodule

// ---- epc_core.sv ----
`timescale 1ns/1ps
module epc_core #(
  parameter logic EXT_EN_DEFAULT = 1'b1
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Configuration
  input wire logic ext_en_prog_i,
  input wire logic ext_en_val_i,
  // Instruction from fetch
  input wire logic [15:0] instr_i,
  input wire logic instr_valid_i,
  // Core state
  input wire logic [epc_pkg::PC_W-1:0] pc_i,
  input wire logic [7:0] working_register_i,
  input wire logic [7:0] pc_latch_high_i,
  input wire logic [4:0] pc_latch_upper_i,
  input wire logic [epc_pkg::PC_W-1:0] return_stack_top_i,
  // Pointers
  output logic [epc_pkg::PTR_W-1:0] ptr0_o,
  output logic [epc_pkg::PTR_W-1:0] ptr1_o,
  output logic [epc_pkg::PTR_W-1:0] frame_pointer_two_o,
  // Program flow
  output logic pc_load_o,
  output logic [epc_pkg::PC_W-1:0] pc_new_o,
  output logic stack_push_o,
  output logic stack_pop_o,
  output logic [epc_pkg::PC_W-1:0] stack_push_data_o,
  output logic fetch_flush_o,
  output logic busy_o
);
  epc_dec_if dif ();
  epc_pkg::epc_state_t state_reg;
  logic ext_en_reg;
  logic [epc_pkg::PTR_W-1:0] ptr_reg [3];
  logic [epc_pkg::PTR_W-1:0] lit_ext;
  logic accept;

  epc_decoder u_dec (
    .instr_i(instr_i),
    .instr_valid_i(instr_valid_i),
    .ext_en_i(ext_en_reg),
    .d(dif)
  );

  // ----------------------------------------
  // Configuration
  // ----------------------------------------
  // Unprogrammed part runs with the extension on
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ext_en_reg <= EXT_EN_DEFAULT;
    end else if (ext_en_prog_i) begin
      ext_en_reg <= ext_en_val_i;
    end
  end

  // New instructions are ignored while the second, idle cycle runs
  assign accept = (state_reg == epc_pkg::EPC_IDLE);
  assign lit_ext = {{(epc_pkg::PTR_W-epc_pkg::LIT_W){1'b0}}, dif.lit};

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_reg <= epc_pkg::EPC_IDLE;
    end else begin
      unique case (state_reg)
        epc_pkg::EPC_IDLE: begin
          if (dif.is_add_ret) begin
            state_reg <= epc_pkg::EPC_RET_NOP;
          end else if (dif.is_call_w) begin
            state_reg <= epc_pkg::EPC_CALL_NOP;
          end
        end
        epc_pkg::EPC_RET_NOP: state_reg <= epc_pkg::EPC_IDLE;
        epc_pkg::EPC_CALL_NOP: state_reg <= epc_pkg::EPC_IDLE;
        default: state_reg <= epc_pkg::EPC_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Pointer file
  // ----------------------------------------
  // No flag outputs exist, so status is untouched by construction
  for (genvar i = 0; i < 3; i++) begin : g_ptr
    always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
        ptr_reg[i] <= epc_pkg::PTR_RST;
      end else if (accept && dif.is_add_ptr && (dif.sel == 2'(i))) begin
        ptr_reg[i] <= ptr_reg[i] + lit_ext;
      end else if (accept && dif.is_add_ret && (2'(i) == epc_pkg::SEL_FRAME_TWO)) begin
        ptr_reg[i] <= ptr_reg[i] + lit_ext;
      end
    end
  end

  assign ptr0_o = ptr_reg[0];
  assign ptr1_o = ptr_reg[1];
  assign frame_pointer_two_o = ptr_reg[epc_pkg::SEL_FRAME_TWO];

  // ----------------------------------------
  // Program flow outputs
  // ----------------------------------------
  // Status and bank registers have no path here; the working register feeds only the call target
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      pc_load_o <= 1'b0;
      pc_new_o <= epc_pkg::PC_RST;
      stack_push_o <= 1'b0;
      stack_pop_o <= 1'b0;
      stack_push_data_o <= epc_pkg::PC_RST;
      fetch_flush_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      pc_load_o <= accept && (dif.is_add_ret || dif.is_call_w);
      stack_push_o <= accept && dif.is_call_w;
      stack_pop_o <= accept && dif.is_add_ret;
      fetch_flush_o <= accept && (dif.is_add_ret || dif.is_call_w);
      busy_o <= accept && (dif.is_add_ret || dif.is_call_w);
      if (accept && dif.is_call_w) begin
        stack_push_data_o <= pc_i + epc_pkg::RET_STEP;
        pc_new_o <= {pc_latch_upper_i, pc_latch_high_i, working_register_i};
      end else if (accept && dif.is_add_ret) begin
        pc_new_o <= return_stack_top_i;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_call_taken;
    accept && dif.is_call_w;
  endsequence
  sequence s_ret_taken;
    accept && dif.is_add_ret;
  endsequence

  a_call_push_addr: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    s_call_taken |=> stack_push_o && stack_push_data_o == $past(pc_i) + epc_pkg::RET_STEP)
    else $error("call push address wrong");
  a_call_target: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    s_call_taken |=> pc_load_o && pc_new_o == {$past(pc_latch_upper_i), $past(pc_latch_high_i),
      $past(working_register_i)})
    else $error("call target wrong");
  a_call_two_cycle: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    s_call_taken |=> state_reg == epc_pkg::EPC_CALL_NOP ##1 accept)
    else $error("call not two cycles");
  a_ret_pop_pc: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    s_ret_taken |=> stack_pop_o && !stack_push_o && pc_new_o == $past(return_stack_top_i))
    else $error("return pop wrong");
  a_ret_frame_add: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    s_ret_taken |=> frame_pointer_two_o == $past(frame_pointer_two_o) + $past(lit_ext)
      && ptr0_o == $past(ptr0_o) && ptr1_o == $past(ptr1_o))
    else $error("return frame add wrong");
  a_ret_two_cycle: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    s_ret_taken |=> !accept ##1 accept && !pc_load_o)
    else $error("return not two cycles");
  a_ptr_add: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    accept && dif.is_add_ptr && dif.sel == 2'h0 |=> ptr0_o == $past(ptr0_o) + $past(lit_ext) && !pc_load_o)
    else $error("pointer add wrong");
  a_ext_gate: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !ext_en_reg |-> !dif.is_call_w && !dif.is_add_ptr && !dif.is_add_ret)
    else $error("decode while disabled");
  a_call_opcode: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    dif.is_call_w |-> instr_i == epc_pkg::OPC_CALL_W)
    else $error("call opcode mismatch");

  // ----------------------------------------
  // Further checks
  // ----------------------------------------
  // Fetch keeps offering words in the no-operation cycle; they must leave no trace
  sequence s_busy_cycle;
    !accept && instr_valid_i;
  endsequence
  sequence s_ptr_one_taken;
    accept && dif.is_add_ptr && dif.sel == 2'h1;
  endsequence
  sequence s_ptr_two_taken;
    accept && dif.is_add_ptr && dif.sel == epc_pkg::SEL_FRAME_TWO;
  endsequence

  a_ptr_add_one: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    s_ptr_one_taken |=> ptr1_o == $past(ptr1_o) + $past(lit_ext) && ptr0_o == $past(ptr0_o))
    else $error("pointer one add wrong");
  a_ptr_add_two: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    s_ptr_two_taken |=> frame_pointer_two_o == $past(frame_pointer_two_o) + $past(lit_ext) && !stack_pop_o)
    else $error("pointer two add wrong");
  a_ptr_hold: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !(accept && (dif.is_add_ptr || dif.is_add_ret)) |=> ptr0_o == $past(ptr0_o)
      && ptr1_o == $past(ptr1_o) && frame_pointer_two_o == $past(frame_pointer_two_o))
    else $error("pointer moved without add");
  a_ret_drop_next: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    s_ret_taken ##1 s_busy_cycle |=> !pc_load_o && !stack_pop_o && !stack_push_o
      && ptr0_o == $past(ptr0_o) && ptr1_o == $past(ptr1_o)
      && frame_pointer_two_o == $past(frame_pointer_two_o))
    else $error("word kept after return");
  a_call_drop_next: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    s_call_taken ##1 s_busy_cycle |=> !pc_load_o && !stack_pop_o && !stack_push_o
      && ptr0_o == $past(ptr0_o) && ptr1_o == $past(ptr1_o)
      && frame_pointer_two_o == $past(frame_pointer_two_o))
    else $error("word kept after call");
  a_call_keep_regs: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    s_call_taken |=> !stack_pop_o && ptr0_o == $past(ptr0_o) && ptr1_o == $past(ptr1_o)
      && frame_pointer_two_o == $past(frame_pointer_two_o))
    else $error("call touched other state");
  a_ext_no_call: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !ext_en_reg && instr_valid_i && instr_i == epc_pkg::OPC_CALL_W |=> !pc_load_o && !stack_push_o && !busy_o)
    else $error("call ran while disabled");
  a_load_single: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    pc_load_o |=> !pc_load_o)
    else $error("pc load longer than one cycle");
  a_load_flush_busy: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    pc_load_o |-> fetch_flush_o && busy_o && !accept)
    else $error("load without flush or idle cycle");
endmodule

// ---- epc_stack_model.sv ----
`timescale 1ns/1ps
module epc_stack_model (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Stack requests
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [epc_pkg::PC_W-1:0] push_data_i,
  // Stack top
  output logic [epc_pkg::PC_W-1:0] top_o
);
  logic [epc_pkg::PC_W-1:0] mem_reg [0:15];
  logic [3:0] sp_reg;
  // Empty stack shows a junk pattern, never a stale entry
  assign top_o = (sp_reg == 4'h0) ? 21'h0aaaaa : mem_reg[sp_reg - 4'h1];
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      sp_reg <= 4'h0;
    end else if (push_i) begin
      mem_reg[sp_reg] <= push_data_i;
      sp_reg <= sp_reg + 4'h1;
    end else if (pop_i && sp_reg != 4'h0) begin
      sp_reg <= sp_reg - 4'h1;
    end
  end
endmodule

// ---- epc_core_tb.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module epc_core_tb;
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic ext_en_prog_i = 1'b0;
  logic ext_en_val_i = 1'b0;
  logic [15:0] instr_i = 16'h0000;
  logic instr_valid_i = 1'b0;
  logic [20:0] pc_i = 21'h000000;
  logic [7:0] working_register_i = 8'h00;
  logic [7:0] pc_latch_high_i = 8'h00;
  logic [4:0] pc_latch_upper_i = 5'h00;
  logic [20:0] return_stack_top_i, pc_new_o, stack_push_data_o;
  logic [11:0] ptr0_o, ptr1_o, frame_pointer_two_o;
  logic pc_load_o, stack_push_o, stack_pop_o, fetch_flush_o, busy_o;
  int err_count = 0;
  int n_compared = 0;
  always #4 ref_clk_i = ~ref_clk_i;
  epc_core dut_u (.ref_clk_i, .srst_i, .ext_en_prog_i, .ext_en_val_i, .instr_i, .instr_valid_i, .pc_i,
    .working_register_i, .pc_latch_high_i, .pc_latch_upper_i, .return_stack_top_i, .ptr0_o, .ptr1_o,
    .frame_pointer_two_o, .pc_load_o, .pc_new_o, .stack_push_o, .stack_pop_o, .stack_push_data_o,
    .fetch_flush_o, .busy_o);
  epc_stack_model stk_u (.ref_clk_i, .srst_i, .push_i(stack_push_o), .pop_i(stack_pop_o),
    .push_data_i(stack_push_data_o), .top_o(return_stack_top_i));
  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic issue(input logic [15:0] w);
    @(posedge ref_clk_i) begin instr_i <= w; instr_valid_i <= 1'b1; end
    @(posedge ref_clk_i) instr_valid_i <= 1'b0;
    #1;
  endtask
  task automatic set_ext(input logic v);
    @(posedge ref_clk_i) begin ext_en_prog_i <= 1'b1; ext_en_val_i <= v; end
    @(posedge ref_clk_i) ext_en_prog_i <= 1'b0;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_add_ptr;
    for (int f = 0; f < 3; f++) begin
      issue({8'he8, f[1:0], 6'h3f});
      issue({8'he8, f[1:0], f[5:0] + 6'h01});
      `CHK(pc_load_o, 1'b0)
    end
    `CHK({ptr0_o, ptr1_o, frame_pointer_two_o}, {12'h040, 12'h041, 12'h042})
  endtask
  task automatic t_disabled;
    set_ext(1'b0);
    issue(16'he805);
    `CHK(ptr0_o, 12'h040)
    issue(16'h0014);
    `CHK({stack_push_o, pc_load_o}, 2'b00)
    set_ext(1'b1);
  endtask
  task automatic t_call;
    @(posedge ref_clk_i) begin
      pc_i <= 21'h001230; working_register_i <= 8'h06; pc_latch_high_i <= 8'h10; pc_latch_upper_i <= 5'h01;
      instr_i <= 16'h0014; instr_valid_i <= 1'b1;
    end
    // Word offered in the no-operation cycle must be dropped
    @(posedge ref_clk_i) instr_i <= 16'he801;
    #1;
    `CHK({stack_push_o, stack_push_data_o}, {1'b1, 21'h001232})
    `CHK({pc_load_o, pc_new_o}, {1'b1, 21'h011006})
    `CHK({fetch_flush_o, busy_o, stack_pop_o}, 3'b110)
    @(posedge ref_clk_i) instr_valid_i <= 1'b0;
    #1;
    `CHK({stack_push_o, pc_load_o, busy_o}, 3'b000)
    `CHK(ptr0_o, 12'h040)
  endtask
  task automatic t_ret;
    issue(16'he8ea);
    `CHK(frame_pointer_two_o, 12'h06c)
    `CHK({ptr0_o, ptr1_o}, {12'h040, 12'h041})
    `CHK({stack_pop_o, pc_load_o, pc_new_o}, {2'b11, 21'h001232})
    `CHK({fetch_flush_o, busy_o, stack_push_o}, 3'b110)
    @(posedge ref_clk_i) #1;
    `CHK({stack_pop_o, pc_load_o, busy_o}, 3'b000)
  endtask
  task automatic tally_and_finish;
    if (err_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    t_add_ptr();
    t_disabled();
    t_call();
    t_ret();
    tally_and_finish();
  end
  initial begin
    repeat (2000) @(posedge ref_clk_i);
    err_count++;
    tally_and_finish();
  end
endmodule
